// [rtl/reset_map.vh]
`ifndef RESET_MAP_VH
`define RESET_MAP_VH

// ****************************************
// Register map
// ****************************************
`define RCC_ADDR_W 8
`define RCC_OFFSET 8'h00
`define RCC_POR_VALUE 16'h2003
`define RCC_IMPL_MASK 16'hf3ff

// ****************************************
// Field positions
// ****************************************
`define BIT_TRAP 15
`define BIT_ILLEGAL 14
`define BIT_SW_BOR_EN 13
`define BIT_RETENTION 12
`define BIT_CFG_MISMATCH 9
`define BIT_FAST_WAKE_DIS 8
`define BIT_EXT_PIN 7
`define BIT_SW_RESET 6
`define BIT_SW_WDT_EN 5
`define BIT_WDT_TIMEOUT 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWNOUT 1
`define BIT_POWER_ON 0

// ****************************************
// Configuration encodings and responses
// ****************************************
`define BOR_CFG_OFF 2'b00
`define BOR_CFG_SOFTWARE 2'b01
`define WDT_CFG_ALWAYS 2'b11
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RELEASE_STAGES 2

`endif

// [rtl/reset_release_sync.v]
`timescale 1ns/1ns
`include "reset_map.vh"

module reset_release_sync
(
  // Clock
  input wire aclk,
  // Combined reset request, level
  input wire reset_req,
  // Synchronised master reset, active high
  output wire master_reset_signal
);

  // Shift chain, all ones while held in reset
  reg [`RELEASE_STAGES-1:0] chain_r;

  // ****************************************
  // Async set, release after clean edges
  // ****************************************
  // Set path needs no clock so a dead clock still holds the core
  always @(posedge aclk or posedge reset_req)
  begin
    if (reset_req)
      chain_r <= {`RELEASE_STAGES{1'b1}};
    else
      chain_r <= {chain_r[`RELEASE_STAGES-2:0], 1'b0};
  end

  // Output straight from the last stage
  assign master_reset_signal = chain_r[`RELEASE_STAGES-1];

endmodule

// [rtl/reset_source_combiner_status.v]
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "reset_map.vh"

module reset_source_combiner_status
(
  // Clock and bus reset (power-on)
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [`RCC_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`RCC_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Reset sources, active high levels
  input wire external_clear_pin,
  input wire reset_instruction,
  input wire watchdog_timeout,
  input wire brownout_detect,
  input wire config_mismatch,
  input wire trap_conflict,
  input wire illegal_opcode,
  input wire uninit_working_reg_reset,
  // Instruction events, one-cycle pulses
  input wire watchdog_clear_instruction,
  input wire power_save_instruction,
  input wire power_save_arg,
  // Configuration fields
  input wire [1:0] brownout_config_field,
  input wire [1:0] watchdog_config_field,
  input wire low_power_config_bit,
  // Master reset and control outputs
  output wire master_reset_signal,
  output reg brownout_enable,
  output reg sleep_retention_active,
  output reg fast_wake_disable,
  output reg watchdog_enable
);

  // ****************************************
  // Address decode
  // ****************************************
  // Shared by the read and write paths
  function is_reg_addr;
    input [`RCC_ADDR_W-1:0] addr;
    begin
      // Both sides of the compare kept at the address width
      is_reg_addr = ({2'b00, addr[`RCC_ADDR_W-1:2]} == (`RCC_OFFSET >> 2));
    end
  endfunction

  // The status and control register
  reg [15:0] reset_cause_and_control_r;
  reg [15:0] reset_cause_and_control_nxt;

  // Latched write address and data
  reg [`RCC_ADDR_W-1:0] aw_addr_r;
  reg aw_full_r;
  reg [15:0] w_data_r;
  reg [1:0] w_strb_r;
  reg w_full_r;

  // Write committed this cycle
  wire wr_go;
  wire wr_hit;

  // Per-bit hardware set, clear and write enable
  wire [15:0] hw_set;
  wire [15:0] hw_clr;
  wire [15:0] wr_en;

  // Combined reset request
  wire any_source;

  // ****************************************
  // Reset source combiner
  // ****************************************
  // Power-on is modelled by the bus reset being low
  assign any_source = ~aresetn
    | external_clear_pin
    | reset_instruction
    | watchdog_timeout
    | brownout_detect
    | config_mismatch
    | trap_conflict
    | illegal_opcode
    | uninit_working_reg_reset;

  // Release is clean even if sources drop mid-cycle
  reset_release_sync u_release
  (
    .aclk (aclk),
    .reset_req (any_source),
    .master_reset_signal (master_reset_signal)
  );

  // ****************************************
  // Hardware flag events
  // ****************************************
  // Each cause lands on its own bit, except illegal_opcode and uninit_working_reg_reset, which share BIT_ILLEGAL
  assign hw_set[`BIT_TRAP] = trap_conflict;
  assign hw_set[`BIT_ILLEGAL] = illegal_opcode
    | uninit_working_reg_reset;
  assign hw_set[`BIT_SW_BOR_EN] = 1'b0;
  assign hw_set[`BIT_RETENTION] = 1'b0;
  assign hw_set[11:10] = 2'b00;
  assign hw_set[`BIT_CFG_MISMATCH] = config_mismatch;
  assign hw_set[`BIT_FAST_WAKE_DIS] = 1'b0;
  assign hw_set[`BIT_EXT_PIN] = external_clear_pin;
  assign hw_set[`BIT_SW_RESET] = reset_instruction;
  assign hw_set[`BIT_SW_WDT_EN] = 1'b0;
  assign hw_set[`BIT_WDT_TIMEOUT] = watchdog_timeout;
  assign hw_set[`BIT_SLEEP] = power_save_instruction
    & ~power_save_arg;
  assign hw_set[`BIT_IDLE] = power_save_instruction
    & power_save_arg;
  assign hw_set[`BIT_BROWNOUT] = brownout_detect;
  assign hw_set[`BIT_POWER_ON] = 1'b0;

  // Only the watchdog flag has an instruction clear
  assign hw_clr = {11'h000,
    watchdog_clear_instruction | power_save_instruction,
    4'h0};

  // ****************************************
  // Software write enables per byte lane
  // ****************************************
  assign wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wr_hit = wr_go & is_reg_addr(aw_addr_r);
  // Unimplemented bits never take a write
  assign wr_en = {{8{wr_hit & w_strb_r[1]}}, {8{wr_hit & w_strb_r[0]}}}
    & `RCC_IMPL_MASK;

  // ****************************************
  // Next value, bit by bit
  // ****************************************
  // Set wins over both a write and a hardware clear
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1)
    begin : g_bit
      always @*
      begin
        if (hw_set[i])
          reset_cause_and_control_nxt[i] = 1'b1;
        else if (hw_clr[i])
          reset_cause_and_control_nxt[i] = 1'b0;
        else if (wr_en[i])
          // Plain store, no reset side effect
          reset_cause_and_control_nxt[i] = w_data_r[i];
        else
          reset_cause_and_control_nxt[i] = reset_cause_and_control_r[i];
      end
    end
  endgenerate

  // ****************************************
  // Status and control register
  // ****************************************
  // Only power-on loads it; other resets leave it alone
  always @(posedge aclk)
  begin
    if (!aresetn)
      reset_cause_and_control_r <= `RCC_POR_VALUE;
    else
      // Kept across master reset from other sources
      reset_cause_and_control_r <= reset_cause_and_control_nxt;
  end

  // ****************************************
  // Control outputs
  // ****************************************
  // Registered, one cycle after the register changes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      brownout_enable <= 1'b1;
      sleep_retention_active <= 1'b0;
      fast_wake_disable <= 1'b0;
      watchdog_enable <= 1'b0;
    end
    else
    begin
      // Software bit counts only in the software mode
      if (brownout_config_field == `BOR_CFG_SOFTWARE)
        brownout_enable <=
          reset_cause_and_control_r[`BIT_SW_BOR_EN];
      else
        brownout_enable <= (brownout_config_field != `BOR_CFG_OFF);
      // Retention regulator absent when config bit is one
      sleep_retention_active <= ~low_power_config_bit
        & reset_cause_and_control_r[`BIT_RETENTION];
      fast_wake_disable <=
        reset_cause_and_control_r[`BIT_FAST_WAKE_DIS];
      // Hard-enabled watchdog cannot be turned off by software
      watchdog_enable <= (watchdog_config_field == `WDT_CFG_ALWAYS)
        | reset_cause_and_control_r[`BIT_SW_WDT_EN];
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data latched in either order; one write at a time
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_r <= {`RCC_ADDR_W{1'b0}};
      aw_full_r <= 1'b0;
      w_data_r <= 16'h0000;
      w_strb_r <= 2'b00;
      w_full_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      // Capture address
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      // Capture data, upper lanes are not wired
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_r <= s_axi_wdata[15:0];
        w_strb_r <= s_axi_wstrb[1:0];
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Commit and respond
      if (wr_go)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (is_reg_addr(aw_addr_r))
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_SLVERR;
      end
      // Reopen only after the response is taken
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  // Data registered on the same edge that takes the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (is_reg_addr(s_axi_araddr))
        begin
          // Upper half and unimplemented bits read zero
          s_axi_rdata <= {16'h0000,
            reset_cause_and_control_r & `RCC_IMPL_MASK};
          s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// [dv/reset_combiner_chk.sv]
`timescale 1ns/1ns
module reset_combiner_chk
(
  // Clock and power-on reset
  input wire aclk,
  input wire aresetn,
  // Read data channel
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  // Reset sources
  input wire external_clear_pin,
  input wire reset_instruction,
  input wire watchdog_timeout,
  input wire brownout_detect,
  input wire config_mismatch,
  input wire trap_conflict,
  input wire illegal_opcode,
  input wire uninit_working_reg_reset,
  // Configuration fields
  input wire [1:0] brownout_config_field,
  input wire [1:0] watchdog_config_field,
  input wire low_power_config_bit,
  // Outputs under watch
  input wire master_reset_signal,
  input wire brownout_enable,
  input wire sleep_retention_active,
  input wire watchdog_enable
);
  // **********
  // Helpers
  // **********
  // Any source asking for reset
  wire any_src = external_clear_pin | reset_instruction | watchdog_timeout |
    brownout_detect | config_mismatch | trap_conflict | illegal_opcode |
    uninit_working_reg_reset;
  // Nothing at all requesting reset
  wire quiet = aresetn & ~any_src;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_src_master: assert property (any_src |-> master_reset_signal)
    else $error("master reset low with a source high");
  a_hold_one: assert property ($past(any_src) |-> master_reset_signal)
    else $error("master reset released too early");
  a_release_two: assert property (quiet [*3] |-> !master_reset_signal)
    else $error("master reset held too long");
  a_no_sw_reset: assert property
    (quiet && $past(quiet) |-> !$rose(master_reset_signal))
    else $error("master reset without a source");
  a_unimpl_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[11:10] == 2'b00)
    else $error("unimplemented bits read nonzero");
  a_bor_off: assert property ($past(aresetn) &&
    $past(brownout_config_field) == 2'b00 |-> !brownout_enable)
    else $error("brownout enabled with field 00");
  a_bor_hw: assert property ($past(aresetn) &&
    $past(brownout_config_field) >= 2'b10 |-> brownout_enable)
    else $error("brownout off with hardware field");
  a_wdt_forced: assert property ($past(aresetn) &&
    $past(watchdog_config_field) == 2'b11 |-> watchdog_enable)
    else $error("watchdog off with field 11");
  a_ret_blocked: assert property ($past(aresetn) &&
    $past(low_power_config_bit) |-> !sleep_retention_active)
    else $error("retention active with config bit one");
  // Main scenarios reached
  c_source: cover property (any_src);
  c_por_read: cover property (s_axi_rvalid && s_axi_rdata[0]);
  c_wdt_forced: cover property (watchdog_config_field == 2'b11);
endmodule
bind reset_source_combiner_status reset_combiner_chk u_chk (.aclk, .aresetn,
  .s_axi_rdata, .s_axi_rvalid, .external_clear_pin, .reset_instruction,
  .watchdog_timeout, .brownout_detect, .config_mismatch, .trap_conflict,
  .illegal_opcode, .uninit_working_reg_reset, .brownout_config_field,
  .watchdog_config_field, .low_power_config_bit, .master_reset_signal,
  .brownout_enable, .sleep_retention_active, .watchdog_enable);

// [dv/reset_source_model.sv]
`timescale 1ns/1ns
module reset_source_model
(
  // Clock and bench command
  input wire logic aclk,
  input wire logic [3:0] sel,
  input wire logic go,
  // Master reset seen by system logic
  input wire logic master_reset_signal,
  // Source levels and instruction pulses
  output logic [10:0] ev,
  output int rst_cycles
);
  // **********
  // Events
  // **********
  initial ev = 11'h000;
  initial rst_cycles = 0;
  // One-cycle event; argument one also raises the instruction
  always @(posedge aclk)
  begin
    ev <= go ? (11'h001 << sel) | {1'b0, sel == 4'd10, 9'h000} : 11'h000;
    rst_cycles <= rst_cycles + int'(master_reset_signal);
  end
endmodule

// [dv/reset_source_combiner_status_tb.sv]
`timescale 1ns/1ns
module reset_source_combiner_status_tb;
  // **********
  // Signals
  // **********
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, go;
  logic s_axi_arvalid, s_axi_rready, low_power_config_bit;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [1:0] brownout_config_field, watchdog_config_field;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, master_reset_signal, brownout_enable;
  logic sleep_retention_active, fast_wake_disable, watchdog_enable;
  logic [3:0] sel;
  logic [10:0] ev;
  int error_cnt, total_checks, rst_cycles, i;
  // Expected flag per source event
  logic [15:0] flag_tab [8] = '{16'h0080, 16'h0040, 16'h0010, 16'h0002,
    16'h0200, 16'h8000, 16'h4000, 16'h4000};
  reset_source_combiner_status u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .external_clear_pin(ev[0]),
    .reset_instruction(ev[1]), .watchdog_timeout(ev[2]),
    .brownout_detect(ev[3]), .config_mismatch(ev[4]), .trap_conflict(ev[5]),
    .illegal_opcode(ev[6]), .uninit_working_reg_reset(ev[7]),
    .watchdog_clear_instruction(ev[8]), .power_save_instruction(ev[9]),
    .power_save_arg(ev[10]), .brownout_config_field, .watchdog_config_field,
    .low_power_config_bit, .master_reset_signal, .brownout_enable,
    .sleep_retention_active, .fast_wake_disable, .watchdog_enable);
  reset_source_model u_src (.aclk, .sel, .go, .master_reset_signal, .ev,
    .rst_cycles);
  // **********
  // Tasks
  // **********
  task final_report;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        error_cnt++;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Valid held up to the rising edge that sees ready; answer taken at a later edge that sees bvalid
  task axi_wr(input logic [7:0] a, input logic [15:0] v);
    int n;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
          r = s_axi_bresp;
          break;
        end
      end
      if (n == 50)
      begin
        error_cnt++;
        final_report;
      end
    end
  endtask
  task axi_rd(input logic [7:0] a);
    int n;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          break;
        end
      end
      if (n == 50)
      begin
        error_cnt++;
        final_report;
      end
    end
  endtask
  // Fire one source or instruction event, wait out the master reset
  task pulse(input logic [3:0] s);
    int n;
    int base;
    begin
      // Model's count of master reset cycles before the event
      base = rst_cycles;
      sel <= s;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      @(negedge aclk);
      if (s < 4'd8)
        chk("master", 1, master_reset_signal);
      for (n = 0; n < 10 && master_reset_signal; n++)
        @(negedge aclk);
      chk("released", 0, master_reset_signal);
      @(posedge aclk);
      // One source cycle plus two release stages
      chk("rst_len", (s < 4'd8) ? 3 : 0, rst_cycles - base);
    end
  endtask
  // **********
  // Stimulus
  // **********
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
    {s_axi_bready, s_axi_rready, sel, low_power_config_bit} = 7'h60;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    brownout_config_field = 2'b01;
    watchdog_config_field = 2'b00;
    error_cnt = 0;
    total_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(8'h00);
    chk("por_value", 16'h2003, d);
    chk("bor_sw_on", 1, brownout_enable);
    axi_wr(8'h00, 16'hffff);
    axi_rd(8'h00);
    chk("all_ones", 16'hf3ff, d);
    chk("no_reset", 0, master_reset_signal);
    chk("retention", 1, sleep_retention_active);
    chk("fast_wake", 1, fast_wake_disable);
    chk("wdt_sw", 1, watchdog_enable);
    low_power_config_bit <= 1'b1;
    watchdog_config_field <= 2'b11;
    brownout_config_field <= 2'b00;
    axi_wr(8'h00, 16'h0000);
    axi_rd(8'h00);
    chk("cleared", 16'h0000, d);
    chk("ret_blocked", 0, sleep_retention_active);
    chk("wdt_forced", 1, watchdog_enable);
    chk("bor_off", 0, brownout_enable);
    chk("fast_wake_en", 0, fast_wake_disable);
    {low_power_config_bit, watchdog_config_field} <= 3'h0;
    brownout_config_field <= 2'b01;
    for (i = 0; i < 8; i++)
    begin
      pulse(4'(i));
      axi_rd(8'h00);
      chk("flag", flag_tab[i], d);
      axi_wr(8'h00, 16'h0000);
    end
    chk("wdt_off", 0, watchdog_enable);
    axi_wr(8'h00, 16'h1100);
    pulse(4'd0);
    axi_rd(8'h00);
    chk("kept", 16'h1180, d);
    axi_wr(8'h00, 16'h0010);
    pulse(4'd8);
    axi_rd(8'h00);
    chk("wdt_clr", 16'h0000, d);
    axi_wr(8'h00, 16'h0010);
    pulse(4'd9);
    pulse(4'd10);
    axi_rd(8'h00);
    chk("sleep_idle", 16'h000c, d);
    axi_wr(8'h04, 16'hffff);
    chk("wr_slverr", 2'b10, r);
    axi_rd(8'h04);
    chk("rd_slverr", 2'b10, r);
    chk("rd_zero", 32'h00000000, d);
    axi_rd(8'h00);
    chk("unmapped", 16'h000c, d);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(8'h00);
    chk("second_por", 16'h2003, d);
    final_report;
  end
endmodule
